// file: pkg/dtdc_pkg.sv
// Summary of operation
// R1 - Mode bit: 0 transmit, 1 demodulate
// R2 - Submode 00 normal, 01 ping-pong
// R3 - Writing normal submode ends ping-pong
// R4 - Submode 10/11 force wide output low/high
// R5 - Demod filter: none, 4, 8 cycles
// R6 - Combine outputs with AND, OR, NOR, NAND
// R7 - Demod edges: falling, rising, both
// R8 - Pin select routes output or demod source
// R9 - Logic field survives stop-mode recovery
// R10 - Eight-bit output starts at initial level
// R11 - Disabled eight-bit output shows inverted level
// R12 - Rising-edge flag, write one clears
// R13 - Falling-edge flag, write one clears
// R14 - Wide output starts at initial level
// R15 - Disabled wide output shows inverted level
// R16 - Enable loads high*256+low, sets level
// R17 - Zero toggles output, sets status, interrupt
// R18 - Single-pass stops, modulo-N reloads
// R19 - Reload bytes take effect at load
// R20 - Software keeps initial bits while enabled
// R21 - Port-three capture raises request two
package dtdc_pkg;

  typedef logic [31:0] dtdc_word_t;
  typedef logic [7:0] dtdc_byte_t;
  typedef logic [5:0] dtdc_idx_t;

  // ----------------------------------------------------------------
  // Register indices, byte address is index times four
  // ----------------------------------------------------------------
  localparam dtdc_idx_t IDX_T8_CTRL = 6'h00;
  localparam dtdc_idx_t IDX_COMMON = 6'h01;
  localparam dtdc_idx_t IDX_WIDE_CTRL = 6'h02;
  localparam dtdc_idx_t IDX_WIDE_RELOAD_HI = 6'h03;
  localparam dtdc_idx_t IDX_WIDE_RELOAD_LO = 6'h04;
  localparam dtdc_idx_t IDX_T8_RELOAD = 6'h05;
  localparam dtdc_idx_t IDX_STATUS = 6'h06;
  localparam dtdc_idx_t IDX_NONE = 6'h3f;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int COM_MODE = 7;
  localparam int COM_PINSEL = 6;
  localparam int COM_LOGIC_LO = 4;
  localparam int COM_SUB_LO = 2;
  localparam int COM_BIT1 = 1;
  localparam int COM_BIT0 = 0;
  localparam int CTL_EN = 7;
  localparam int CTL_SINGLE = 6;
  localparam int CTL_STAT = 5;
  localparam int CTL_IEN = 1;

  // ----------------------------------------------------------------
  // Reset values and codes
  // ----------------------------------------------------------------
  localparam dtdc_byte_t RELOAD_RST = 8'h00;
  localparam logic [1:0] FIELD_RST = 2'h0;
  localparam logic [1:0] SUB_NORMAL = 2'h0;
  localparam logic [1:0] SUB_PING_PONG = 2'h1;
  localparam logic [1:0] SUB_FORCE_LOW = 2'h2;
  localparam logic [1:0] SUB_FORCE_HIGH = 2'h3;
  localparam logic [1:0] FLT_NONE = 2'h0;
  localparam logic [1:0] FLT_SHORT = 2'h1;
  localparam logic [1:0] FLT_LONG = 2'h2;
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h2;
  localparam logic [1:0] LOGIC_AND = 2'h0;
  localparam logic [1:0] LOGIC_OR = 2'h1;
  localparam logic [1:0] LOGIC_NOR = 2'h2;
  localparam logic [1:0] LOGIC_NAND = 2'h3;

  // ----------------------------------------------------------------
  // Timing, in system clock cycles
  // ----------------------------------------------------------------
  localparam logic [3:0] FILTER_SHORT_CYC = 4'h4;
  localparam logic [3:0] FILTER_LONG_CYC = 4'h8;

endpackage : dtdc_pkg

// file: pkg/dtdc_demod_if.sv
interface dtdc_demod_if;
  logic sample;
  logic [1:0] filter_sel;
  logic [1:0] edge_sel;
  logic level;
  logic rise_evt;
  logic fall_evt;

  modport core (output sample, output filter_sel, output edge_sel, input level, input rise_evt, input fall_evt);
  modport det (input sample, input filter_sel, input edge_sel, output level, output rise_evt, output fall_evt);
endinterface : dtdc_demod_if

// file: src/dtdc_edge_detect.sv
module dtdc_edge_detect (
  input wire logic clock,
  input wire logic srst,
  dtdc_demod_if.det dif
);
  import dtdc_pkg::*;

  logic level_q;
  logic rise_q;
  logic fall_q;
  logic [3:0] run_q;
  logic [3:0] need;
  logic differ;
  logic accept;

  // ----------------------------------------------------------------
  // Glitch filter
  // ----------------------------------------------------------------
  // Reserved code falls back to no filtering
  always_comb begin
    case (dif.filter_sel)
      FLT_SHORT: need = FILTER_SHORT_CYC; // R5
      FLT_LONG: need = FILTER_LONG_CYC; // R5
      default: need = 4'h1;
    endcase
  end

  assign differ = dif.sample != level_q;
  assign accept = differ && (run_q + 4'h1 >= need);

  always_ff @(posedge clock) begin
    if (srst || !differ || accept) begin
      run_q <= 4'h0;
    end else begin
      run_q <= run_q + 4'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      level_q <= 1'b0;
    end else if (accept) begin
      level_q <= dif.sample;
    end
  end

  // ----------------------------------------------------------------
  // Edge selection
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (srst) begin
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end else begin
      rise_q <= accept && dif.sample && (dif.edge_sel == EDGE_RISE || dif.edge_sel == EDGE_BOTH); // R7
      fall_q <= accept && !dif.sample && (dif.edge_sel == EDGE_FALL || dif.edge_sel == EDGE_BOTH); // R7
    end
  end

  assign dif.level = level_q;
  assign dif.rise_evt = rise_q;
  assign dif.fall_evt = fall_q;

endmodule : dtdc_edge_detect

// file: src/dtdc_top.sv
// The AHB-Lite interface to the registers is this design's own decision.
module dtdc_top (
  input wire logic clock,
  input wire logic srst,
  input wire logic stop_recover,
  input wire logic hsel,
  input wire dtdc_pkg::dtdc_word_t haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire dtdc_pkg::dtdc_word_t hwdata,
  input wire logic hready,
  output dtdc_pkg::dtdc_word_t hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic port_out_data,
  input wire logic port_three_demod_input,
  input wire logic port_two_demod_input,
  output logic eight_bit_counter_output,
  output logic sixteen_bit_counter_output,
  output logic shared_waveform_pin_o,
  output logic shared_waveform_pin_oe,
  output logic wide_timer_irq,
  output logic interrupt_request_two
);
  import dtdc_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  dtdc_demod_if dif ();

  logic wr_q;
  dtdc_idx_t widx_q;
  dtdc_word_t hrdata_q;
  dtdc_byte_t wbyte;
  dtdc_byte_t rd_byte;
  logic take;

  logic mode_q;
  logic pinsel_q;
  logic [1:0] logic_q;
  logic [1:0] sub_q;
  logic init8_q;
  logic init16_q;
  logic rflag_q;
  logic fflag_q;
  logic pp_q;

  logic t8_en_q;
  logic t8_single_q;
  logic t8_stat_q;
  dtdc_byte_t t8_reload_q;
  dtdc_byte_t t8_cnt_q;
  logic eight_bit_counter_output_q;

  logic t16_en_q;
  logic t16_single_q;
  logic t16_stat_q;
  logic t16_ien_q;
  dtdc_byte_t rel_hi_q;
  dtdc_byte_t rel_lo_q;
  logic [15:0] t16_cnt_q;
  logic sixteen_bit_counter_output_q;

  logic pin_q;
  logic interrupt_request_two_q;

  logic w_t8;
  logic w_com;
  logic w_wide;
  logic t8_start;
  logic t16_start;
  logic t8_zero;
  logic t16_zero;
  logic forced;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic dtdc_idx_t reg_idx(input dtdc_word_t addr);
    if (addr[31:8] != 24'h000000 || addr[1:0] != 2'h0) begin
      return IDX_NONE;
    end
    return addr[7:2];
  endfunction : reg_idx

  function automatic logic combine(input logic a, input logic b, input logic [1:0] sel);
    case (sel)
      LOGIC_AND: return a & b;
      LOGIC_OR: return a | b;
      LOGIC_NOR: return ~(a | b);
      default: return ~(a & b);
    endcase
  endfunction : combine

  // ----------------------------------------------------------------
  // AHB-Lite slave, zero wait states
  // ----------------------------------------------------------------
  assign take = hsel && hready && htrans[1];
  assign wbyte = hwdata[7:0];

  always_ff @(posedge clock) begin
    if (srst) begin
      wr_q <= 1'b0;
      widx_q <= IDX_NONE;
    end else begin
      wr_q <= take && hwrite;
      widx_q <= reg_idx(haddr);
    end
  end

  // Read data is caught at the address phase, so it stands in the data phase
  always_ff @(posedge clock) begin
    if (srst) begin
      hrdata_q <= 32'h00000000;
    end else if (take && !hwrite) begin
      hrdata_q <= {24'h000000, rd_byte};
    end
  end

  always_comb begin
    case (reg_idx(haddr))
      IDX_T8_CTRL: rd_byte = {t8_en_q, t8_single_q, t8_stat_q, 5'h00};
      IDX_COMMON: rd_byte = {mode_q, pinsel_q, logic_q, sub_q, mode_q ? {rflag_q, fflag_q} : {init8_q, init16_q}};
      IDX_WIDE_CTRL: rd_byte = {t16_en_q, t16_single_q, t16_stat_q, 3'h0, t16_ien_q, 1'b0};
      IDX_WIDE_RELOAD_HI: rd_byte = rel_hi_q;
      IDX_WIDE_RELOAD_LO: rd_byte = rel_lo_q;
      IDX_T8_RELOAD: rd_byte = t8_reload_q;
      IDX_STATUS: rd_byte = {3'h0, pp_q, dif.level, pin_q, sixteen_bit_counter_output_q, eight_bit_counter_output_q};
      default: rd_byte = 8'h00;
    endcase
  end

  assign hrdata = hrdata_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  assign w_t8 = wr_q && widx_q == IDX_T8_CTRL;
  assign w_com = wr_q && widx_q == IDX_COMMON;
  assign w_wide = wr_q && widx_q == IDX_WIDE_CTRL;

  // ----------------------------------------------------------------
  // Common control
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (srst || stop_recover) begin
      mode_q <= 1'b0;
      pinsel_q <= 1'b0;
      sub_q <= SUB_NORMAL;
      init8_q <= 1'b0;
      init16_q <= 1'b0;
    end else if (w_com) begin
      mode_q <= wbyte[COM_MODE]; // R1
      pinsel_q <= wbyte[COM_PINSEL]; // R8
      sub_q <= wbyte[COM_SUB_LO +: 2]; // R2
      if (!mode_q) begin
        init8_q <= wbyte[COM_BIT1]; // R10
        init16_q <= wbyte[COM_BIT0]; // R14
      end
    end
  end

  // Only the system reset reaches this field
  always_ff @(posedge clock) begin
    if (srst) begin
      logic_q <= FIELD_RST; // R9
    end else if (w_com) begin
      logic_q <= wbyte[COM_LOGIC_LO +: 2]; // R6
    end
  end

  // Edge flags, a new edge beats a clear in the same cycle
  always_ff @(posedge clock) begin
    if (srst || stop_recover) begin
      rflag_q <= 1'b0;
      fflag_q <= 1'b0;
    end else begin
      rflag_q <= (rflag_q && !(w_com && mode_q && wbyte[COM_BIT1])) || (mode_q && dif.rise_evt); // R12
      fflag_q <= (fflag_q && !(w_com && mode_q && wbyte[COM_BIT0])) || (mode_q && dif.fall_evt); // R13
    end
  end

  // Ping-pong sequence state
  always_ff @(posedge clock) begin
    if (srst || stop_recover) begin
      pp_q <= 1'b0;
    end else if (w_com) begin
      pp_q <= !wbyte[COM_MODE] && wbyte[COM_SUB_LO +: 2] == SUB_PING_PONG; // R2 R3
    end
  end

  assign forced = !mode_q && (sub_q == SUB_FORCE_LOW || sub_q == SUB_FORCE_HIGH);

  // ----------------------------------------------------------------
  // Demodulator input
  // ----------------------------------------------------------------
  assign dif.sample = pinsel_q ? port_two_demod_input : port_three_demod_input; // R8
  assign dif.filter_sel = sub_q;
  assign dif.edge_sel = logic_q;

  dtdc_edge_detect u_edge (
    .clock(clock),
    .srst(srst),
    .dif(dif.det)
  );

  // Masking of this request lives in the interrupt controller
  always_ff @(posedge clock) begin
    if (srst) begin
      interrupt_request_two_q <= 1'b0;
    end else begin
      interrupt_request_two_q <= mode_q && !pinsel_q && (dif.rise_evt || dif.fall_evt); // R21
    end
  end

  assign interrupt_request_two = interrupt_request_two_q;

  // ----------------------------------------------------------------
  // Start and terminal conditions
  // ----------------------------------------------------------------
  assign t8_zero = t8_en_q && t8_cnt_q == 8'h00;
  assign t16_zero = t16_en_q && t16_cnt_q == 16'h0000;
  // Ping-pong hands the run to the other counter at each terminal count
  assign t8_start = (w_t8 && wbyte[CTL_EN] && !t8_en_q) || (pp_q && t16_zero);
  assign t16_start = (w_wide && wbyte[CTL_EN] && !t16_en_q) || (pp_q && t8_zero);

  // ----------------------------------------------------------------
  // Eight-bit counter
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (srst) begin
      t8_en_q <= 1'b0;
      t8_single_q <= 1'b0;
    end else if (t8_start) begin
      t8_en_q <= 1'b1;
      // A starting write must still latch its own pass mode
      if (w_t8) begin
        t8_single_q <= wbyte[CTL_SINGLE];
      end
    end else if (w_t8) begin
      t8_en_q <= wbyte[CTL_EN];
      t8_single_q <= wbyte[CTL_SINGLE];
    end else if (t8_zero && (t8_single_q || pp_q)) begin
      t8_en_q <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      t8_stat_q <= 1'b0;
    end else begin
      t8_stat_q <= (t8_stat_q && !(w_t8 && wbyte[CTL_STAT])) || t8_zero;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      t8_reload_q <= RELOAD_RST;
    end else if (wr_q && widx_q == IDX_T8_RELOAD) begin
      t8_reload_q <= wbyte;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      t8_cnt_q <= RELOAD_RST;
      eight_bit_counter_output_q <= 1'b1;
    end else if (t8_start) begin
      t8_cnt_q <= t8_reload_q;
      eight_bit_counter_output_q <= init8_q; // R10
    end else if (!t8_en_q) begin
      eight_bit_counter_output_q <= !init8_q; // R11
    end else if (t8_zero) begin
      t8_cnt_q <= t8_reload_q;
      eight_bit_counter_output_q <= !eight_bit_counter_output_q;
    end else begin
      t8_cnt_q <= t8_cnt_q - 8'h01;
    end
  end

  assign eight_bit_counter_output = eight_bit_counter_output_q;

  // ----------------------------------------------------------------
  // Sixteen-bit counter
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (srst) begin
      t16_en_q <= 1'b0;
      t16_single_q <= 1'b0;
      t16_ien_q <= 1'b0;
    end else if (t16_start) begin
      t16_en_q <= 1'b1;
      if (w_wide) begin
        t16_single_q <= wbyte[CTL_SINGLE];
        t16_ien_q <= wbyte[CTL_IEN];
      end
    end else if (w_wide) begin
      t16_en_q <= wbyte[CTL_EN];
      t16_single_q <= wbyte[CTL_SINGLE];
      t16_ien_q <= wbyte[CTL_IEN];
    end else if (t16_zero && (t16_single_q || pp_q)) begin
      t16_en_q <= 1'b0; // R18
    end
  end

  // Status is set by the terminal count, cleared by writing one
  always_ff @(posedge clock) begin
    if (srst) begin
      t16_stat_q <= 1'b0;
    end else begin
      t16_stat_q <= (t16_stat_q && !(w_wide && wbyte[CTL_STAT])) || t16_zero; // R17
    end
  end

  // Written any time, used only when the counter loads
  always_ff @(posedge clock) begin
    if (srst) begin
      rel_hi_q <= RELOAD_RST;
      rel_lo_q <= RELOAD_RST;
    end else if (wr_q && widx_q == IDX_WIDE_RELOAD_HI) begin
      rel_hi_q <= wbyte; // R19
    end else if (wr_q && widx_q == IDX_WIDE_RELOAD_LO) begin
      rel_lo_q <= wbyte; // R19
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      t16_cnt_q <= 16'h0000;
    end else if (t16_start || t16_zero) begin
      t16_cnt_q <= {rel_hi_q, rel_lo_q}; // R16 R18
    end else if (t16_en_q) begin
      t16_cnt_q <= t16_cnt_q - 16'h0001;
    end
  end

  // Forced codes win over everything, even while counting
  always_ff @(posedge clock) begin
    if (srst) begin
      sixteen_bit_counter_output_q <= 1'b1;
    end else if (forced) begin
      sixteen_bit_counter_output_q <= sub_q == SUB_FORCE_HIGH; // R4
    end else if (t16_start) begin
      sixteen_bit_counter_output_q <= init16_q; // R14 R16
    end else if (!t16_en_q) begin
      sixteen_bit_counter_output_q <= !init16_q; // R15
    end else if (t16_zero) begin
      sixteen_bit_counter_output_q <= !sixteen_bit_counter_output_q; // R17
    end
  end

  assign sixteen_bit_counter_output = sixteen_bit_counter_output_q;
  assign wide_timer_irq = t16_stat_q && t16_ien_q; // R17

  // ----------------------------------------------------------------
  // Shared pin
  // ----------------------------------------------------------------
  // Changing initial levels mid-run glitches this pin; software avoids it
  always_ff @(posedge clock) begin
    if (srst) begin
      pin_q <= 1'b0;
    end else if (pinsel_q) begin
      pin_q <= combine(eight_bit_counter_output_q, sixteen_bit_counter_output_q, logic_q); // R6 R8 R20
    end else begin
      pin_q <= port_out_data; // R8
    end
  end

  assign shared_waveform_pin_o = pin_q;
  assign shared_waveform_pin_oe = !mode_q;

endmodule : dtdc_top

// file: tb/dtdc_monitor.sv
module dtdc_monitor (
  input wire logic clock,
  input wire logic srst,
  input wire logic stop_recover,
  input wire logic hsel,
  input wire dtdc_pkg::dtdc_word_t haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire dtdc_pkg::dtdc_word_t hwdata,
  input wire logic port_out_data,
  input wire logic eight_bit_counter_output,
  input wire logic sixteen_bit_counter_output,
  input wire logic shared_waveform_pin_o,
  input wire logic shared_waveform_pin_oe,
  input wire logic wide_timer_irq,
  input wire logic interrupt_request_two
);
  timeunit 1ns;
  timeprecision 100ps;
  import dtdc_pkg::*;
  // ------
  // Shadow of register writes
  // ------
  logic ph_q;
  logic wr_q;
  logic [7:0] adr_q;
  dtdc_byte_t com_q;
  dtdc_byte_t wide_q;
  dtdc_byte_t t8_q;
  logic w_com;
  logic w_wide;
  logic w_t8;
  logic port_mode;
  assign w_com = ph_q && wr_q && adr_q == 8'h04;
  assign w_wide = ph_q && wr_q && adr_q == 8'h08;
  assign w_t8 = ph_q && wr_q && adr_q == 8'h00;
  assign port_mode = !com_q[7] && !com_q[6];
  always_ff @(posedge clock) begin
    ph_q <= !srst && hsel && hready && htrans[1] && haddr[31:8] == 24'h0;
    wr_q <= hwrite;
    adr_q <= haddr[7:0];
  end
  // Demod flags share bits 1:0, so they only follow writes in transmit
  always_ff @(posedge clock) begin
    if (srst) begin
      com_q <= 8'h00;
    end else if (stop_recover) begin
      com_q <= com_q & 8'h30;
    end else if (w_com) begin
      com_q <= {hwdata[7:2], com_q[7] ? com_q[1:0] : hwdata[1:0]};
    end
  end
  always_ff @(posedge clock) begin
    if (srst) begin
      wide_q <= 8'h00;
      t8_q <= 8'h00;
    end else begin
      wide_q <= w_wide ? hwdata[7:0] : wide_q;
      t8_q <= w_t8 ? hwdata[7:0] : t8_q;
    end
  end
  // ------
  // Checks
  // ------
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  force_low_a: assert property (w_com && !hwdata[7] && hwdata[3:2] == 2'h2 |-> ##[1:3] !sixteen_bit_counter_output)
    else $error("forced low not seen");
  force_high_a: assert property (w_com && !hwdata[7] && hwdata[3:2] == 2'h3 |-> ##[1:3] sixteen_bit_counter_output)
    else $error("forced high not seen");
  pin_route_a: assert property (port_mode && $past(port_mode) && !$past(srst) |->
    shared_waveform_pin_o == $past(port_out_data))
    else $error("pin does not follow port data");
  pin_enable_a: assert property (shared_waveform_pin_oe == !com_q[7])
    else $error("pin enable wrong for mode");
  // Request is registered, so it reflects the source of the cycle before
  req_two_src_a: assert property (interrupt_request_two |-> $past(com_q[7] && !com_q[6]))
    else $error("request two from wrong source");
  wide_irq_a: assert property (wide_timer_irq |-> wide_q[1])
    else $error("wide interrupt while disabled");
  wide_start_a: assert property (w_wide && hwdata[7] && !wide_q[7] && !com_q[7] && !com_q[3] |=>
    sixteen_bit_counter_output == com_q[0])
    else $error("wide start level wrong");
  eight_start_a: assert property (w_t8 && hwdata[7] && !t8_q[7] && !com_q[7] |=>
    eight_bit_counter_output == com_q[1])
    else $error("eight start level wrong");
endmodule : dtdc_monitor

bind dtdc_top dtdc_monitor mon_u (.clock, .srst, .stop_recover, .hsel, .haddr, .htrans, .hwrite, .hready,
  .hwdata, .port_out_data, .eight_bit_counter_output, .sixteen_bit_counter_output, .shared_waveform_pin_o,
  .shared_waveform_pin_oe, .wide_timer_irq, .interrupt_request_two);

// file: tb/dtdc_far_end.sv
module dtdc_far_end (
  input wire logic clock,
  input wire logic go,
  input wire logic src_two,
  input wire logic [3:0] pulse_len,
  output logic port_three_demod_input,
  output logic port_two_demod_input
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] cnt_q = 4'h0;
  logic tog_q = 1'b0;
  always @(posedge clock) begin
    cnt_q <= go ? pulse_len : (cnt_q == 4'h0 ? 4'h0 : cnt_q - 4'h1);
    tog_q <= !tog_q;
  end
  // Unused source is not held still: it wiggles every cycle
  assign port_three_demod_input = src_two ? tog_q : cnt_q != 4'h0;
  assign port_two_demod_input = src_two ? cnt_q != 4'h0 : tog_q;
endmodule : dtdc_far_end

// file: tb/dtdc_tb.sv
module dtdc_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import dtdc_pkg::*;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic stop_recover = 1'b0;
  logic hsel = 1'b0;
  dtdc_word_t haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  dtdc_word_t hwdata = 32'h0;
  logic hready;
  logic port_out_data = 1'b0;
  logic go = 1'b0;
  logic src_two = 1'b0;
  logic [3:0] pulse_len = 4'h0;
  logic port_three_demod_input;
  logic port_two_demod_input;
  dtdc_word_t hrdata;
  logic hreadyout;
  logic hresp;
  logic eight_bit_counter_output;
  logic sixteen_bit_counter_output;
  logic shared_waveform_pin_o;
  logic shared_waveform_pin_oe;
  logic wide_timer_irq;
  logic interrupt_request_two;
  int error_cnt = 0;
  int comparisons = 0;
  // Rows: common byte, pulse length, expected flags
  logic [15:0] rows [9] = '{16'h8331, 16'h9332, 16'ha333, 16'hb330, 16'ha730, 16'ha753,
    16'hab70, 16'hab93, 16'he333};
  assign hready = hreadyout;
  dtdc_top dut_u (.clock, .srst, .stop_recover, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hrdata, .hreadyout, .hresp, .port_out_data, .port_three_demod_input, .port_two_demod_input,
    .eight_bit_counter_output, .sixteen_bit_counter_output, .shared_waveform_pin_o, .shared_waveform_pin_oe,
    .wide_timer_irq, .interrupt_request_two);
  dtdc_far_end far_u (.clock, .go, .src_two, .pulse_len, .port_three_demod_input, .port_two_demod_input);
  initial begin
    forever #12.5 clock = ~clock;
  end
  // ------
  // Tasks
  // ------
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : print_verdict
  task automatic chk(input dtdc_word_t got, input dtdc_word_t exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_pin(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask : chk_pin
  // Bounded wait so a stuck ready ends the run
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (hready !== 1'b1 && n < 16);
    if (hready !== 1'b1) begin
      error_cnt++;
      print_verdict();
    end
  endtask : wait_rdy
  task automatic xfer(input logic w, input dtdc_idx_t i, input dtdc_byte_t d, output dtdc_word_t r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, i, 2'h0};
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    wait_rdy();
    r = hrdata;
  endtask : xfer
  task automatic wr(input dtdc_idx_t i, input dtdc_byte_t d);
    dtdc_word_t r;
    xfer(1'b1, i, d, r);
  endtask : wr
  task automatic rd(input dtdc_idx_t i, input dtdc_word_t m, input dtdc_word_t e);
    dtdc_word_t r;
    xfer(1'b0, i, 8'h00, r);
    chk(r & m, e);
  endtask : rd
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask : cyc
  task automatic togs(input int n, input int e);
    logic p;
    int c;
    c = 0;
    // Sample mid-cycle, away from the edge that launches the output
    @(negedge clock);
    p = sixteen_bit_counter_output;
    repeat (n) begin
      @(negedge clock);
      c += (sixteen_bit_counter_output !== p);
      p = sixteen_bit_counter_output;
    end
    @(posedge clock);
    chk(32'(c), 32'(e));
  endtask : togs
  task automatic done_test(input string s);
    $display("test %s done, mismatches %0d", s, error_cnt);
  endtask : done_test
  // ------
  // Sequence
  // ------
  initial begin
    int n2;
    repeat (4) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    rd(IDX_COMMON, 32'hffffffff, 32'h0);
    wr(IDX_NONE, 8'hff);
    rd(IDX_NONE, 32'hffffffff, 32'h0);
    chk_pin(eight_bit_counter_output, 1'b1);
    chk_pin(sixteen_bit_counter_output, 1'b1);
    chk_pin(shared_waveform_pin_oe, 1'b1);
    done_test("reset");
    // Init bits only change while both counters are stopped
    wr(IDX_COMMON, 8'h03);
    cyc(2);
    chk_pin(eight_bit_counter_output, 1'b0);
    chk_pin(sixteen_bit_counter_output, 1'b0);
    wr(IDX_WIDE_RELOAD_HI, 8'h00);
    wr(IDX_WIDE_RELOAD_LO, 8'h05);
    wr(IDX_T8_RELOAD, 8'h03);
    wr(IDX_T8_CTRL, 8'hc0);
    wr(IDX_WIDE_CTRL, 8'hc2);
    cyc(1);
    chk_pin(sixteen_bit_counter_output, 1'b1);
    togs(30, 1);
    chk_pin(wide_timer_irq, 1'b1);
    rd(IDX_WIDE_CTRL, 32'h20, 32'h20);
    wr(IDX_WIDE_CTRL, 8'h22);
    cyc(1);
    chk_pin(wide_timer_irq, 1'b0);
    wr(IDX_WIDE_RELOAD_LO, 8'h01);
    wr(IDX_WIDE_CTRL, 8'h80);
    togs(20, 10);
    wr(IDX_WIDE_CTRL, 8'h20);
    wr(IDX_T8_CTRL, 8'h20);
    done_test("counters");
    wr(IDX_COMMON, 8'h08);
    cyc(3);
    chk_pin(sixteen_bit_counter_output, 1'b0);
    wr(IDX_COMMON, 8'h0d);
    cyc(3);
    chk_pin(sixteen_bit_counter_output, 1'b1);
    wr(IDX_COMMON, 8'h04);
    rd(IDX_STATUS, 32'h10, 32'h10);
    wr(IDX_COMMON, 8'h00);
    rd(IDX_STATUS, 32'h10, 32'h0);
    done_test("submode");
    for (int l = 0; l < 4; l++) begin
      wr(IDX_COMMON, 8'h41 | 8'(l << 4));
      cyc(3);
      chk_pin(shared_waveform_pin_o, l[0]);
    end
    wr(IDX_COMMON, 8'h31);
    port_out_data <= 1'b1;
    cyc(3);
    chk_pin(shared_waveform_pin_o, 1'b1);
    stop_recover <= 1'b1;
    cyc(1);
    stop_recover <= 1'b0;
    rd(IDX_COMMON, 32'hff, 32'h30);
    done_test("combine");
    foreach (rows[k]) begin
      src_two <= rows[k][14];
      wr(IDX_COMMON, rows[k][15:8]);
      cyc(10);
      // Second write clears flags left by the source switch
      wr(IDX_COMMON, rows[k][15:8]);
      go <= 1'b1;
      pulse_len <= rows[k][7:4];
      n2 = 0;
      @(posedge clock);
      go <= 1'b0;
      repeat (30) begin
        @(posedge clock);
        n2 += (interrupt_request_two === 1'b1);
      end
      rd(IDX_COMMON, 32'h03, {30'h0, rows[k][1:0]});
      chk(32'(n2), rows[k][14] ? 32'h0 : 32'($countones(rows[k][1:0])));
    end
    done_test("demod");
    print_verdict();
  end
endmodule : dtdc_tb
